//--- rtl/flash_erase_and_sleep_sequencer.sv
// Instruction decoder and self-timed erase and sleep control of a serial flash.
`timescale 1ns/1ps
module flash_erase_and_sleep_sequencer
   import flash_seq_pkg::*;
#(
   parameter int ADDR_BITS       = ADDR_BITS_BIG,
   parameter int SECTORS         = SECTORS_MAX,
   parameter int BLOCK_CLEAR_CNT = BLOCK_CLEAR_CYC,
   parameter int ARRAY_CLEAR_CNT = ARRAY_CLEAR_CYC,
   parameter int WAKE_CNT        = WAKE_CYC
)
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               reset_n,
   input  wire logic               sel_n,
   input  wire logic               sclk,
   input  wire logic               sdi,
   input  wire logic [SECTORS-1:0] hw_protect,
   input  wire logic [SECTORS-1:0] sw_protect,
   output logic                    sdo,
   output logic                    sdo_oe,
   output logic                    cycle_active_flag,
   output logic                    write_armed_latch,
   output logic                    deep_sleep,
   output logic                    sleep_pending,
   output logic                    erase_strobe,
   output logic                    erase_whole,
   output logic [1:0]              erase_sector
);

   localparam int CNT_W = 32;

   spi_pins_t pins_in;
   spi_pins_t pins_sync;
   logic      rst_n_sync;
   logic      sclk_d_reg;
   logic      sel_n_d_reg;
   logic      rise_sclk;
   logic      fall_sclk;
   logic      sel_rise;
   logic      sel_fall;
   logic      in_reset;

   assign pins_in = '{sel_n: sel_n, sclk: sclk, sdi: sdi};

   // Select idles high, so it resets to the deselected level.
   pin_sync #(.WIDTH(3), .INIT(3'h4)) u_spi_sync
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (pins_in),
      .sync_out (pins_sync)
   );

   pin_sync #(.WIDTH(1), .INIT(1'h1)) u_rst_sync
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (reset_n),
      .sync_out (rst_n_sync)
   );

   // The pin reset acts like power-up: any running cycle is abandoned.
   assign in_reset = sys_rst || !rst_n_sync;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sclk_d_reg  <= 1'b0;
         sel_n_d_reg <= 1'b1;
      end
      else
      begin
         sclk_d_reg  <= pins_sync.sclk;
         sel_n_d_reg <= pins_sync.sel_n;
      end
   end

   assign rise_sclk = pins_sync.sclk && !sclk_d_reg && !pins_sync.sel_n;
   assign fall_sclk = !pins_sync.sclk && sclk_d_reg && !pins_sync.sel_n;
   assign sel_rise  = pins_sync.sel_n && !sel_n_d_reg;
   assign sel_fall  = !pins_sync.sel_n && sel_n_d_reg;

   // Shifting: count of bits since select fell, and the bits themselves.
   logic [5:0]  bit_cnt_reg;
   logic [31:0] shift_reg;
   logic        overrun_reg;

   always_ff @(posedge clk)
   begin
      if (in_reset || sel_fall)
      begin
         bit_cnt_reg <= 6'h00;
         shift_reg   <= 32'h0;
         overrun_reg <= 1'b0;
      end
      else if (rise_sclk)
      begin
         shift_reg <= {shift_reg[30:0], pins_sync.sdi};
         if (bit_cnt_reg == 6'h3f)
            overrun_reg <= 1'b1;
         else
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
   end

   logic [7:0] opcode;
   logic       ends_at_code;
   logic       ends_at_addr;

   // The opcode sits in the top byte after 32 bits, the low byte after 8.
   assign opcode       = (bit_cnt_reg == 6'd32) ? shift_reg[31:24] : shift_reg[7:0];
   assign ends_at_code = (bit_cnt_reg == 6'd8) && !overrun_reg;
   assign ends_at_addr = (bit_cnt_reg == 6'd32) && !overrun_reg;

   function automatic logic [1:0] sector_of(input logic [31:0] frame);
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] mask;
      addr = frame[ADDR_W-1:0];
      mask = ADDR_W'((1 << ADDR_BITS) - 1);
      addr = addr & mask;
      sector_of = addr[SECTOR_LSB+1:SECTOR_LSB];
   endfunction : sector_of

   logic [1:0] tgt_sector;
   assign tgt_sector = sector_of(shift_reg);

   // Power and cycle state.
   pwr_state_t  state_reg;
   logic [CNT_W-1:0] timer_reg;
   logic        armed_reg;
   erase_req_t  req_reg;
   logic        busy;
   logic        go_block;
   logic        go_array;
   logic        go_sleep;
   logic        go_wake;
   logic        go_unlock;

   assign busy = (state_reg == PWR_CYCLE);

   always_comb
   begin
      go_block  = 1'b0;
      go_array  = 1'b0;
      go_sleep  = 1'b0;
      go_wake   = 1'b0;
      go_unlock = 1'b0;
      if (sel_rise)
      begin
         case (state_reg)
            PWR_STANDBY:
            begin
               // Hardware-protected sectors, or any protection bit for an array clear, drop the request silently.
               go_block  = ends_at_addr && opcode == CMD_BLOCK_CLEAR && armed_reg
                           && !hw_protect[tgt_sector];
               go_array  = ends_at_code && opcode == CMD_ARRAY_CLEAR && armed_reg
                           && hw_protect == '0 && sw_protect == '0;
               go_sleep  = ends_at_code && opcode == CMD_DEEP_SLEEP;
               go_unlock = ends_at_code && opcode == CMD_WRITE_UNLOCK;
            end
            PWR_SLEEP:
               go_wake = ends_at_code && opcode == CMD_WAKE;
            default:
            begin
               // A running cycle or a pending transition takes nothing new.
               go_block = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (in_reset)
      begin
         state_reg <= PWR_STANDBY;
         timer_reg <= '0;
      end
      else
      begin
         case (state_reg)
            PWR_STANDBY:
            begin
               if (go_block || go_array)
               begin
                  state_reg <= PWR_CYCLE;
                  timer_reg <= go_array ? CNT_W'(ARRAY_CLEAR_CNT - 1)
                                        : CNT_W'(BLOCK_CLEAR_CNT - 1);
               end
               else if (go_sleep)
               begin
                  state_reg <= PWR_ENTERING;
                  timer_reg <= CNT_W'(SLEEP_ENTRY_CYC - 1);
               end
            end
            PWR_CYCLE, PWR_ENTERING, PWR_WAKING:
            begin
               if (timer_reg == '0)
                  state_reg <= (state_reg == PWR_ENTERING) ? PWR_SLEEP
                                                           : PWR_STANDBY;
               else
                  timer_reg <= timer_reg - CNT_W'(1);
            end
            PWR_SLEEP:
            begin
               if (go_wake)
               begin
                  state_reg <= PWR_WAKING;
                  timer_reg <= CNT_W'(WAKE_CNT - 1);
               end
            end
            default:
               state_reg <= PWR_STANDBY;
         endcase
      end
   end

   // The latch drops a fixed few cycles before the cycle's end.
   always_ff @(posedge clk)
   begin
      if (in_reset)
         armed_reg <= 1'b0;
      else if (busy && timer_reg == CNT_W'(LATCH_DROP_CYC))
         armed_reg <= 1'b0;
      else if (go_unlock)
         armed_reg <= 1'b1;
   end

   // Erase request to the array, one pulse at cycle start.
   always_ff @(posedge clk)
   begin
      if (in_reset)
         req_reg <= '0;
      else
      begin
         req_reg.valid <= go_block || go_array;
         if (go_block || go_array)
         begin
            req_reg.whole  <= go_array;
            req_reg.sector <= tgt_sector;
         end
      end
   end

   // Status read: the busy and armed bits shift out on falling clock edges.
   logic [7:0] status_sh_reg;
   logic       status_on_reg;
   logic       sdo_reg;

   always_ff @(posedge clk)
   begin
      if (in_reset || pins_sync.sel_n)
      begin
         status_on_reg <= 1'b0;
         status_sh_reg <= 8'h00;
         sdo_reg       <= 1'b0;
      end
      else if (state_reg != PWR_SLEEP && state_reg != PWR_ENTERING
               && bit_cnt_reg == 6'd8 && !status_on_reg && !overrun_reg
               && shift_reg[7:0] == CMD_READ_STATUS)
      begin
         status_on_reg <= 1'b1;
         status_sh_reg <= {6'h00, armed_reg, busy};
      end
      else if (status_on_reg && fall_sclk)
      begin
         sdo_reg       <= status_sh_reg[7];
         status_sh_reg <= {status_sh_reg[6:0], status_sh_reg[7]};
      end
   end

   assign sdo               = sdo_reg;
   assign sdo_oe            = status_on_reg;
   assign cycle_active_flag = busy;
   assign write_armed_latch = armed_reg;
   assign deep_sleep        = (state_reg == PWR_SLEEP);
   assign sleep_pending     = (state_reg == PWR_ENTERING) || (state_reg == PWR_WAKING);
   assign erase_strobe      = req_reg.valid;
   assign erase_whole       = req_reg.whole;
   assign erase_sector      = req_reg.sector;

endmodule : flash_erase_and_sleep_sequencer

//--- pkg/flash_seq_pkg.sv
// Shared types and constants for the erase and sleep sequencer.
package flash_seq_pkg;

   localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] CMD_BLOCK_CLEAR  = 8'hd8;
   localparam logic [7:0] CMD_ARRAY_CLEAR  = 8'hc7;
   localparam logic [7:0] CMD_DEEP_SLEEP   = 8'hb9;
   localparam logic [7:0] CMD_WAKE         = 8'hab;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h05;

   localparam int CLK_PERIOD_NS = 10;
   localparam int T_BLOCK_CLEAR_US = 1000;
   localparam int T_ARRAY_CLEAR_US = 2000;
   localparam int T_SLEEP_ENTRY_NS = 3000;
   localparam int T_WAKE_NS        = 30000;
   localparam int BLOCK_CLEAR_CYC  = (T_BLOCK_CLEAR_US * 1000) / CLK_PERIOD_NS;
   localparam int ARRAY_CLEAR_CYC  = (T_ARRAY_CLEAR_US * 1000) / CLK_PERIOD_NS;
   localparam int SLEEP_ENTRY_CYC  = (T_SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC         = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LATCH_DROP_CYC   = 2;

   localparam int ADDR_W        = 24;
   localparam int ADDR_BITS_BIG = 18;
   localparam int SECTOR_LSB    = 16;
   localparam int SECTORS_MAX   = 4;

   typedef enum logic [2:0]
   {
      PWR_STANDBY  = 3'b000,
      PWR_CYCLE    = 3'b001,
      PWR_ENTERING = 3'b011,
      PWR_SLEEP    = 3'b010,
      PWR_WAKING   = 3'b110
   } pwr_state_t;

   typedef struct packed
   {
      logic       valid;
      logic       whole;
      logic [1:0] sector;
   } erase_req_t;

   typedef struct packed
   {
      logic sel_n;
      logic sclk;
      logic sdi;
   } spi_pins_t;

endpackage : flash_seq_pkg

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a group of pins.
`timescale 1ns/1ps
module pin_sync
#(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : pin_sync

//--- bench/flash_seq_chk.sv
// Port assertions for the erase and sleep sequencer.
`timescale 1ns/1ps
module flash_seq_chk
   import flash_seq_pkg::*;
#(
   parameter int SECTORS         = SECTORS_MAX,
   parameter int BLOCK_CLEAR_CNT = BLOCK_CLEAR_CYC,
   parameter int ARRAY_CLEAR_CNT = ARRAY_CLEAR_CYC
)
(
   input wire logic               clk,
   input wire logic               sys_rst,
   input wire logic               reset_n,
   input wire logic [SECTORS-1:0] hw_protect,
   input wire logic [SECTORS-1:0] sw_protect,
   input wire logic               cycle_active_flag,
   input wire logic               write_armed_latch,
   input wire logic               deep_sleep,
   input wire logic               erase_strobe,
   input wire logic               erase_whole,
   input wire logic [1:0]         erase_sector
);
   int   run_reg;
   logic whole_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Counts how long the busy flag has stood, so its length can be checked.
   always_ff @(posedge clk)
   begin
      run_reg <= (cycle_active_flag && !sys_rst) ? run_reg + 1 : 0;
   end
   always_ff @(posedge clk)
   begin
      whole_reg <= erase_strobe ? erase_whole : whole_reg;
   end
   strobe_start_a: assert property ($rose(cycle_active_flag) |-> erase_strobe)
      else $error("busy flag rose without a strobe");
   strobe_pulse_a: assert property (erase_strobe |=> !erase_strobe && cycle_active_flag)
      else $error("strobe not a single pulse");
   strobe_armed_a: assert property (erase_strobe |-> $past(write_armed_latch))
      else $error("erase started without armed latch");
   latch_clear_a: assert property ($fell(cycle_active_flag) |-> !write_armed_latch)
      else $error("latch still set at cycle end");
   busy_refuse_a: assert property ($past(cycle_active_flag) |-> !erase_strobe)
      else $error("erase started while busy");
   sector_prot_a: assert property (erase_strobe && !erase_whole |-> !hw_protect[erase_sector])
      else $error("protected sector erased");
   array_prot_a: assert property (erase_strobe && erase_whole |-> !(|{hw_protect, sw_protect}))
      else $error("array erased under protection");
   sleep_quiet_a: assert property (deep_sleep |-> !erase_strobe)
      else $error("erase started in deep sleep");
   cycle_len_a: assert property (@(posedge clk) disable iff (sys_rst || !reset_n)
      $fell(cycle_active_flag) |-> run_reg == (whole_reg ? ARRAY_CLEAR_CNT : BLOCK_CLEAR_CNT))
      else $error("erase cycle length wrong");
endmodule : flash_seq_chk

//--- bench/spi_host_model.sv
// Behavioural SPI host that frames instructions for the sequencer.
`timescale 1ns/1ps
module spi_host_model
(
   output logic      sel_n,
   output logic      sclk,
   output logic      sdi,
   input  wire logic sdo
);
   logic [7:0] rx;
   initial
   begin
      sel_n = 1'b1;
      sclk  = 1'b0;
      sdi   = 1'b0;
      rx    = 8'h00;
   end
   // Sends nbits from bit 31 down; the serial clock stands still outside frames.
   task automatic frame(input logic [31:0] word, input int nbits);
      sel_n = 1'b0;
      #203;
      for (int i = 0; i < nbits; i++)
      begin
         sdi = word[31-i];
         #62.5 sclk = 1'b1;
         rx = {rx[6:0], sdo};
         #62.5 sclk = 1'b0;
      end
      #100 sel_n = 1'b1;
      sdi = ~sdi;
      #400;
   endtask : frame
endmodule : spi_host_model

//--- bench/tb_flash_erase_and_sleep_sequencer.sv
// Self-checking bench for the erase and sleep sequencer.
`timescale 1ns/1ps
module tb_flash_erase_and_sleep_sequencer;
   import flash_seq_pkg::*;
   localparam int BLOCK_CLEAR_CNT = 400;
   localparam int ARRAY_CLEAR_CNT = 1500;
   logic       clk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1;
   logic [3:0] hw_protect = 4'h0, sw_protect = 4'h0;
   logic       sel_n, sclk, sdi, sdo, sdo_oe, cycle_active_flag, write_armed_latch;
   logic       deep_sleep, sleep_pending, erase_strobe, erase_whole, whole_seen;
   logic [1:0] erase_sector, sector_seen;
   int         num_errors = 0, compares = 0, strobes = 0, s0, oe_seen = 0;
   always #5 clk = ~clk;
   always @(negedge clk)
   begin
      if (sdo_oe === 1'b1)
         oe_seen++;
      if (erase_strobe === 1'b1)
      begin
         strobes++;
         whole_seen  = erase_whole;
         sector_seen = erase_sector;
      end
   end
   spi_host_model i_spi_host_model (.sel_n, .sclk, .sdi, .sdo);
   flash_erase_and_sleep_sequencer #(.BLOCK_CLEAR_CNT(BLOCK_CLEAR_CNT),
      .ARRAY_CLEAR_CNT(ARRAY_CLEAR_CNT), .WAKE_CNT(20)) i_flash_erase_and_sleep_sequencer
      (.clk, .sys_rst, .reset_n, .sel_n, .sclk, .sdi, .hw_protect, .sw_protect, .sdo,
      .sdo_oe, .cycle_active_flag, .write_armed_latch, .deep_sleep, .sleep_pending,
      .erase_strobe, .erase_whole, .erase_sector);
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : check
   task automatic report_and_stop;
      $display("counts: %0d compares, %0d mismatches", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // Waits on the busy flag (sel 0) or the sleep state (sel 1) under a bound.
   task automatic wait_sig(input int sel, input logic v);
      int n;
      n = 0;
      while ((sel == 0 ? cycle_active_flag : deep_sleep) !== v)
      begin
         @(posedge clk);
         n++;
         if (n > 4000)
         begin
            num_errors++;
            $display("mismatch at %0t: wait ran out", $time);
            report_and_stop();
         end
      end
   endtask : wait_sig
   // Frames start just after a clock edge, so that every frame of an even number of bits ends, and every
   // check after it happens, well away from a rising edge.
   task automatic send(input logic [7:0] code, input logic [23:0] addr, input int nbits);
      @(posedge clk);
      #1;
      i_spi_host_model.frame({code, addr}, nbits);
   endtask : send
   task automatic drive_prot(input logic [3:0] hw, input logic [3:0] sw);
      @(posedge clk);
      #1 hw_protect = hw;
      sw_protect = sw;
   endtask : drive_prot
   task automatic t_sector;
      s0 = strobes;
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      check(8'(write_armed_latch), 8'h1, "latch after unlock");
      send(CMD_BLOCK_CLEAR, 24'hfe5a5a, 32);
      check(8'(strobes - s0), 8'h1, "sector erase count");
      check({6'h0, sector_seen}, 8'h2, "sector from masked address");
      check(8'(whole_seen), 8'h0, "sector erase kind");
      oe_seen = 0;
      send(CMD_READ_STATUS, 24'h0, 16);
      // The latch only drops a couple of cycles before the end, so it still reads set here.
      check({6'h0, i_spi_host_model.rx[1:0]}, 8'h3, "status mid cycle");
      check(8'(oe_seen > 0), 8'h1, "status output enable");
      wait_sig(0, 1'b0);
      check(8'(write_armed_latch), 8'h0, "latch after cycle");
      send(CMD_READ_STATUS, 24'h0, 16);
      check({6'h0, i_spi_host_model.rx[1:0]}, 8'h0, "status after cycle");
      $display("t_sector done");
   endtask : t_sector
   task automatic t_refuse;
      s0 = strobes;
      send(CMD_BLOCK_CLEAR, 24'h0, 32);
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_BLOCK_CLEAR, 24'h0, 31);
      send(CMD_ARRAY_CLEAR, 24'h0, 9);
      check(8'(strobes - s0), 8'h0, "misframed erase executed");
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_protect;
      s0 = strobes;
      drive_prot(4'h2, 4'h0);
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_BLOCK_CLEAR, 24'h010000, 32);
      drive_prot(4'h0, 4'h2);
      send(CMD_ARRAY_CLEAR, 24'h0, 8);
      check(8'(strobes - s0), 8'h0, "protected erase executed");
      send(CMD_BLOCK_CLEAR, 24'h010000, 32);
      check({6'h0, sector_seen}, 8'h1, "unprotected sector erase");
      wait_sig(0, 1'b0);
      drive_prot(4'h0, 4'h0);
      $display("t_protect done");
   endtask : t_protect
   task automatic t_array;
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_ARRAY_CLEAR, 24'h0, 8);
      s0 = strobes;
      check(8'(whole_seen), 8'h1, "array erase kind");
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_DEEP_SLEEP, 24'h0, 8);
      send(CMD_BLOCK_CLEAR, 24'h0, 32);
      check(8'(strobes - s0), 8'h0, "erase accepted while busy");
      check(8'({sleep_pending, cycle_active_flag}), 8'h1, "busy cycle disturbed");
      wait_sig(0, 1'b0);
      $display("t_array done");
   endtask : t_array
   task automatic t_abort;
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_ARRAY_CLEAR, 24'h0, 8);
      @(posedge clk);
      #1 reset_n = 1'b0;
      repeat (10) @(posedge clk);
      check(8'({write_armed_latch, cycle_active_flag}), 8'h0, "abort on reset pin");
      #1 reset_n = 1'b1;
      #500;
      $display("t_abort done");
   endtask : t_abort
   task automatic t_sleep;
      s0 = strobes;
      send(CMD_DEEP_SLEEP, 24'h0, 8);
      check(8'({sleep_pending, deep_sleep}), 8'h2, "sleep entry delay");
      wait_sig(1, 1'b1);
      oe_seen = 0;
      send(CMD_READ_STATUS, 24'h0, 16);
      check(8'(oe_seen), 8'h0, "status answered in sleep");
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      send(CMD_ARRAY_CLEAR, 24'h0, 8);
      check({write_armed_latch, 7'(strobes - s0)}, 8'h0, "accepted in sleep");
      send(CMD_WAKE, 24'h0, 9);
      check(8'(deep_sleep), 8'h1, "wake with extra clock");
      send(CMD_WAKE, 24'h0, 8);
      wait_sig(1, 1'b0);
      check(8'(sleep_pending), 8'h0, "standby after wake");
      send(CMD_WRITE_UNLOCK, 24'h0, 8);
      check(8'(write_armed_latch), 8'h1, "unlock in standby");
      $display("t_sleep done");
   endtask : t_sleep
   initial
   begin
      repeat (3) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (3) @(posedge clk);
      check(8'({deep_sleep, write_armed_latch, cycle_active_flag}), 8'h0, "power up");
      t_sector();
      t_refuse();
      t_protect();
      t_array();
      t_abort();
      t_sleep();
      report_and_stop();
   end
endmodule : tb_flash_erase_and_sleep_sequencer
bind flash_erase_and_sleep_sequencer flash_seq_chk #(.SECTORS(SECTORS),
   .BLOCK_CLEAR_CNT(BLOCK_CLEAR_CNT), .ARRAY_CLEAR_CNT(ARRAY_CLEAR_CNT)) i_flash_seq_chk
   (.clk, .sys_rst, .reset_n, .hw_protect, .sw_protect, .cycle_active_flag,
   .write_armed_latch, .deep_sleep, .erase_strobe, .erase_whole, .erase_sector);
